/* File: hw/pcc_config_regs.sv */
module pcc_config_regs #(
  parameter logic [15:0] VENDOR_CODE = 16'h1ab0, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h0c5e // Arbitrary value
) (
  input wire logic clk, // Bus clock, 25 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic cfgRead, // Configuration read strobe
  input wire logic cfgWrite, // Configuration write strobe
  input wire logic [7:0] cfgAddr, // Configuration byte address
  input wire logic [3:0] cfgByteEn, // Byte lanes, active high
  input wire logic [31:0] cfgWrData, // Write data
  output logic [31:0] cfgRdData, // Read data, registered
  output logic cfgRdValid, // Read data valid pulse
  input wire logic [31:0] adIn, // Sampled AD lines
  input wire logic [3:0] cbeIn, // Sampled byte enables, active high
  input wire logic parIn, // Sampled PAR line
  input wire logic tgtAddrPhase, // Address phase as seen by the target
  input wire logic memHit, // Address decodes to a memory window
  input wire logic ioHit, // Address decodes to the I/O window
  input wire logic tgtDataPhase, // Target data phase with IRDY and TRDY
  input wire logic mstRdDataPhase, // Own memory read data phase
  input wire logic mstWrPerrSeen, // Target PERR seen on own memory write
  input wire logic masterAbortEvt, // Own master cycle ended by master abort
  input wire logic targetAbortEvt, // Own master cycle ended by target abort
  input wire logic capLoadValid, // Serial memory load strobe for bit 20
  input wire logic capLoadValue, // Loaded capability-list value
  input wire logic masterReqIn, // Datapath wants the bus
  output logic masterReqOut, // Bus request towards arbiter logic
  output logic devselStart, // Start claiming the cycle
  output logic perrOutN, // PERR pin level
  output logic perrOe, // PERR pin enable
  output logic serrOutN, // SERR pin level, open drain
  output logic serrOe // SERR pin enable
);
  logic ioEn_q;
  logic memEn_q;
  logic mstEn_q;
  logic perrResp_q;
  logic serrEn_q;
  logic capList_q;
  logic [31:0] rdData_q;
  logic rdValid_q;
  logic [pcc_pkg::DEVSEL_DELAY-1:0] claim_q;
  logic [1:0] mstRdDly_q;
  logic perrAct_q;
  logic perrRel_q;
  logic serrAct_q;
  logic selIdent;
  logic selCmdSts;
  logic wrCmd;
  logic claimNow;
  logic addrErr;
  logic dataErr;
  logic flagDetPerr;
  logic flagSigSerr;
  logic flagMabort;
  logic flagTabort;
  logic flagMstPerr;
  logic clrDetPerr;
  logic clrSigSerr;
  logic clrMabort;
  logic clrTabort;
  logic clrMstPerr;
  logic setSigSerr;
  logic setMstPerr;
  logic [31:0] cmdStsWord;
  logic [31:0] rdWord;

  assign selIdent = cfgAddr[7:2] == pcc_pkg::OFS_IDENT[7:2];
  assign selCmdSts = cfgAddr[7:2] == pcc_pkg::OFS_CMDSTS[7:2];
  assign wrCmd = cfgWrite & selCmdSts;

  // Command bits, each lane written on its own enable
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ioEn_q <= pcc_pkg::RST_IO_EN;
      memEn_q <= pcc_pkg::RST_MEM_EN;
      mstEn_q <= pcc_pkg::RST_MST_EN;
      perrResp_q <= pcc_pkg::RST_PERR_RESP;
    end
    else if (wrCmd && cfgByteEn[pcc_pkg::LANE_CMD_LO])
    begin
      ioEn_q <= cfgWrData[pcc_pkg::BIT_IO_EN];
      memEn_q <= cfgWrData[pcc_pkg::BIT_MEM_EN];
      mstEn_q <= cfgWrData[pcc_pkg::BIT_MST_EN];
      perrResp_q <= cfgWrData[pcc_pkg::BIT_PERR_RESP];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      serrEn_q <= pcc_pkg::RST_SERR_EN;
    else if (wrCmd && cfgByteEn[pcc_pkg::LANE_CMD_HI])
      serrEn_q <= cfgWrData[pcc_pkg::BIT_SERR_EN];
  end

  // Software cannot write bit 20; only the serial memory loader can
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      capList_q <= pcc_pkg::RST_CAP_LIST;
    else if (capLoadValid)
      capList_q <= capLoadValue;
  end

  // Bus mastering is refused outright while bit 2 is clear
  assign masterReqOut = masterReqIn & mstEn_q;

  // Claim only in enabled spaces, a fixed two clocks on
  assign claimNow = tgtAddrPhase & ((memHit & memEn_q) | (ioHit & ioEn_q));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      claim_q <= '0;
    else
      claim_q <= {claim_q[pcc_pkg::DEVSEL_DELAY-2:0], claimNow};
  end

  assign devselStart = claim_q[pcc_pkg::DEVSEL_DELAY-1];

  pcc_parity_check #(
    .WIDTH(pcc_pkg::PAR_WIDTH)
  ) u_addr_par (
    .clk(clk),
    .rst(rst),
    .phaseValid(tgtAddrPhase),
    .phaseBits({cbeIn, adIn}),
    .parIn(parIn),
    .errPulse(addrErr)
  );

  pcc_parity_check #(
    .WIDTH(pcc_pkg::PAR_WIDTH)
  ) u_data_par (
    .clk(clk),
    .rst(rst),
    .phaseValid(tgtDataPhase | mstRdDataPhase),
    .phaseBits({cbeIn, adIn}),
    .parIn(parIn),
    .errPulse(dataErr)
  );

  // Tracks whether a data error belongs to one of our own reads
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mstRdDly_q <= 2'h0;
    else
      mstRdDly_q <= {mstRdDly_q[0], mstRdDataPhase};
  end

  // PERR is low one clock then driven high one clock before release
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      perrAct_q <= 1'b0;
      perrRel_q <= 1'b0;
    end
    else
    begin
      perrAct_q <= dataErr & perrResp_q;
      perrRel_q <= perrAct_q;
    end
  end

  assign perrOe = perrAct_q | perrRel_q;
  assign perrOutN = ~perrAct_q;

  assign setSigSerr = addrErr & serrEn_q & perrResp_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      serrAct_q <= 1'b0;
    else
      serrAct_q <= setSigSerr;
  end

  assign serrOe = serrAct_q;
  assign serrOutN = ~serrAct_q;

  assign setMstPerr = perrResp_q & ((dataErr & mstRdDly_q[1]) | mstWrPerrSeen);

  // Flags clear only for lanes enabled and bits written one
  assign clrDetPerr = wrCmd & cfgByteEn[pcc_pkg::LANE_STS_HI] & cfgWrData[pcc_pkg::BIT_DET_PERR];
  assign clrSigSerr = wrCmd & cfgByteEn[pcc_pkg::LANE_STS_HI] & cfgWrData[pcc_pkg::BIT_SIG_SERR];
  assign clrMabort = wrCmd & cfgByteEn[pcc_pkg::LANE_STS_HI] & cfgWrData[pcc_pkg::BIT_RCV_MABORT];
  assign clrTabort = wrCmd & cfgByteEn[pcc_pkg::LANE_STS_HI] & cfgWrData[pcc_pkg::BIT_RCV_TABORT];
  assign clrMstPerr = wrCmd & cfgByteEn[pcc_pkg::LANE_STS_HI] & cfgWrData[pcc_pkg::BIT_MST_DPERR];

  pcc_sticky_flag u_det_perr (
    .clk(clk),
    .rst(rst),
    .setEvt(addrErr | dataErr),
    .clrReq(clrDetPerr),
    .flag(flagDetPerr)
  );

  pcc_sticky_flag u_sig_serr (
    .clk(clk),
    .rst(rst),
    .setEvt(setSigSerr),
    .clrReq(clrSigSerr),
    .flag(flagSigSerr)
  );

  pcc_sticky_flag u_mabort (
    .clk(clk),
    .rst(rst),
    .setEvt(masterAbortEvt),
    .clrReq(clrMabort),
    .flag(flagMabort)
  );

  pcc_sticky_flag u_tabort (
    .clk(clk),
    .rst(rst),
    .setEvt(targetAbortEvt),
    .clrReq(clrTabort),
    .flag(flagTabort)
  );

  pcc_sticky_flag u_mst_perr (
    .clk(clk),
    .rst(rst),
    .setEvt(setMstPerr),
    .clrReq(clrMstPerr),
    .flag(flagMstPerr)
  );

  // Fields not assembled here read as zero by construction
  always_comb
  begin
    cmdStsWord = 32'h0;
    cmdStsWord[pcc_pkg::BIT_IO_EN] = ioEn_q;
    cmdStsWord[pcc_pkg::BIT_MEM_EN] = memEn_q;
    cmdStsWord[pcc_pkg::BIT_MST_EN] = mstEn_q;
    cmdStsWord[pcc_pkg::BIT_PERR_RESP] = perrResp_q;
    cmdStsWord[pcc_pkg::BIT_SERR_EN] = serrEn_q;
    cmdStsWord[pcc_pkg::BIT_CAP_LIST] = capList_q;
    cmdStsWord[pcc_pkg::BIT_MST_DPERR] = flagMstPerr;
    cmdStsWord[pcc_pkg::BIT_DEVSEL_LO +: 2] = pcc_pkg::DEVSEL_MEDIUM;
    cmdStsWord[pcc_pkg::BIT_RCV_TABORT] = flagTabort;
    cmdStsWord[pcc_pkg::BIT_RCV_MABORT] = flagMabort;
    cmdStsWord[pcc_pkg::BIT_SIG_SERR] = flagSigSerr;
    cmdStsWord[pcc_pkg::BIT_DET_PERR] = flagDetPerr;
  end

  always_comb
  begin
    if (selIdent)
      rdWord = {DEVICE_CODE, VENDOR_CODE};
    else if (selCmdSts)
      rdWord = cmdStsWord;
    else
      rdWord = 32'h0;
  end

  // Whole dword returned; the bus side picks its lanes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdData_q <= 32'h0;
      rdValid_q <= 1'b0;
    end
    else
    begin
      rdValid_q <= cfgRead;
      if (cfgRead)
        rdData_q <= rdWord;
    end
  end

  assign cfgRdData = rdData_q;
  assign cfgRdValid = rdValid_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_DET_PERR_SET: assert property ((addrErr || dataErr) |=> flagDetPerr)
    else $error("Parity error did not set detected-parity flag");

  AST_DET_PERR_KEEP: assert property (flagDetPerr && !clrDetPerr |=> flagDetPerr)
    else $error("Detected-parity flag lost without a one written");

  AST_SERR_GATED: assert property ($rose(serrOe) |-> $past(serrEn_q) && $past(perrResp_q) && $past(addrErr))
    else $error("SERR driven without both enables and an address error");

  AST_SERR_FLAG: assert property (serrOe |-> flagSigSerr)
    else $error("SERR driven but signalled-system-error flag clear");

  AST_MABORT: assert property (masterAbortEvt |=> flagMabort ##1 flagMabort || $past(clrMabort))
    else $error("Master abort not recorded");

  AST_TABORT: assert property (targetAbortEvt |=> flagTabort)
    else $error("Received target abort not recorded");

  AST_STS_CONST: assert property (cfgRead && selCmdSts |=> cfgRdValid && cfgRdData[27] == 1'b0
    && cfgRdData[26:25] == 2'h1 && cfgRdData[23:21] == 3'h0 && cfgRdData[19:10] == 10'h0)
    else $error("Fixed status fields read wrongly");

  AST_CMD_ZERO: assert property (cfgRead && selCmdSts |=> cfgRdData[9] == 1'b0 && cfgRdData[7] == 1'b0
    && cfgRdData[5:3] == 3'h0)
    else $error("Hardwired command bits read nonzero");

  AST_DEVSEL_TIME: assert property (claimNow |-> ##2 devselStart)
    else $error("Claim not two clocks after address phase");

  AST_DEVSEL_CAUSE: assert property (devselStart |-> $past(tgtAddrPhase, 2) && ($past(memEn_q, 2)
    || $past(ioEn_q, 2)))
    else $error("Cycle claimed with its space disabled");

  AST_PERR_WAVE: assert property ($rose(perrAct_q) |-> $past(perrResp_q) ##1 (perrOe && perrOutN)
    ##1 !perrOe)
    else $error("PERR drive not gated or not released properly");

  AST_MST_PERR: assert property ($rose(flagMstPerr) |-> $past(perrResp_q))
    else $error("Master data parity flag set with parity response off");

  AST_MST_GATE: assert property (wrCmd && cfgByteEn[0] && !cfgWrData[2] |=> !masterReqOut [*2])
    else $error("Bus request passed with master enable cleared");

  AST_UNMAPPED: assert property (cfgRead && !selIdent && !selCmdSts |=> cfgRdData == 32'h0)
    else $error("Unmapped offset returned nonzero");

  AST_IDENT: assert property (cfgRead && selIdent |=> cfgRdData == {DEVICE_CODE, VENDOR_CODE})
    else $error("Identification word wrong");

  AST_W0_KEEPS: assert property (wrCmd && !cfgWrData[29] && flagMabort |=> flagMabort)
    else $error("Writing zero cleared a status flag");

  COV_ADDR_SERR: cover property (setSigSerr ##1 serrOe);
  COV_MST_PERR: cover property (mstRdDataPhase ##2 dataErr ##1 flagMstPerr);
  COV_CLAIM: cover property (tgtAddrPhase && memHit ##2 devselStart);
  COV_CLR_RACE: cover property (clrMabort && masterAbortEvt ##1 flagMabort);
endmodule : pcc_config_regs

/* File: hw/pcc_parity_check.sv */
module pcc_parity_check #(
  parameter int WIDTH = pcc_pkg::PAR_WIDTH
) (
  input wire logic clk, // Bus clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic phaseValid, // Phase whose bits are to be checked
  input wire logic [WIDTH-1:0] phaseBits, // Address/data and byte enables of the phase
  input wire logic parIn, // Even parity bit, arrives one clock after the phase
  output logic errPulse // One-cycle mismatch flag, two clocks after the phase
);
  logic calc_q;
  logic pend_q;
  logic err_q;

  if (WIDTH < 1)
  begin : gen_bad_width
    $error("pcc_parity_check: WIDTH must be at least one");
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      calc_q <= 1'b0;
      pend_q <= 1'b0;
    end
    else
    begin
      calc_q <= ^phaseBits;
      pend_q <= phaseValid;
    end
  end

  // The parity line lags its phase by one clock, hence the held sum
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      err_q <= 1'b0;
    else
      err_q <= pend_q & (calc_q ^ parIn);
  end

  assign errPulse = err_q;
endmodule : pcc_parity_check

/* File: hw/pcc_sticky_flag.sv */
module pcc_sticky_flag (
  input wire logic clk, // Bus clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic setEvt, // Hardware event, one cycle
  input wire logic clrReq, // Software write of one to this bit
  output logic flag // Sticky flag state
);
  logic flag_q;
  logic flag_d;

  // An event in the clearing cycle must not be lost, so set beats clear
  always_comb
  begin
    flag_d = setEvt | (flag_q & ~clrReq);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      flag_q <= pcc_pkg::RST_FLAG;
    else
      flag_q <= flag_d;
  end

  assign flag = flag_q;
endmodule : pcc_sticky_flag

/* File: inc/pcc_pkg.sv */
package pcc_pkg;
  // Dword offsets of the configuration header, as byte addresses
  localparam logic [7:0] OFS_IDENT = 8'h00;
  localparam logic [7:0] OFS_CMDSTS = 8'h04;
  // Command half field positions
  localparam int BIT_IO_EN = 0;
  localparam int BIT_MEM_EN = 1;
  localparam int BIT_MST_EN = 2;
  localparam int BIT_PERR_RESP = 6;
  localparam int BIT_SERR_EN = 8;
  // Status half field positions
  localparam int BIT_CAP_LIST = 20;
  localparam int BIT_MST_DPERR = 24;
  localparam int BIT_DEVSEL_LO = 25;
  localparam int BIT_RCV_TABORT = 28;
  localparam int BIT_RCV_MABORT = 29;
  localparam int BIT_SIG_SERR = 30;
  localparam int BIT_DET_PERR = 31;
  // Byte lanes that carry the writable fields
  localparam int LANE_CMD_LO = 0;
  localparam int LANE_CMD_HI = 1;
  localparam int LANE_STS_HI = 3;
  // Values after reset
  localparam logic RST_IO_EN = 1'b1;
  localparam logic RST_MEM_EN = 1'b1;
  localparam logic RST_MST_EN = 1'b1;
  localparam logic RST_PERR_RESP = 1'b0;
  localparam logic RST_SERR_EN = 1'b0;
  localparam logic RST_CAP_LIST = 1'b1;
  localparam logic RST_FLAG = 1'b0;
  // Medium decode speed code and its claim delay in clocks
  localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
  localparam int DEVSEL_DELAY = 2;
  // Parity covers 32 address/data bits plus 4 byte enables
  localparam int PAR_WIDTH = 36;
endpackage : pcc_pkg

/* File: tb/pcc_host_model.sv */
module pcc_host_model (
  input wire logic clk, // Bus clock
  output logic cfgRead, // Read strobe
  output logic cfgWrite, // Write strobe
  output logic [7:0] cfgAddr, // Byte address
  output logic [3:0] cfgByteEn, // Byte lanes
  output logic [31:0] cfgWrData, // Write data
  input wire logic [31:0] cfgRdData, // Read data
  input wire logic cfgRdValid, // Read valid
  output logic [31:0] adIn, // AD lines
  output logic [3:0] cbeIn, // Byte enables
  output logic parIn, // Parity line
  output logic tgtAddrPhase, // Target address phase
  output logic memHit, // Memory window hit
  output logic ioHit, // I/O window hit
  output logic tgtDataPhase, // Target data phase
  output logic mstRdDataPhase // Own read data phase
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] AD_PAT = 32'h5a3c_0f81;
  localparam logic [3:0] CBE_PAT = 4'h6;

  initial
  begin
    {cfgRead, cfgWrite, cfgAddr, cfgByteEn, cfgWrData} = '0;
    {adIn, cbeIn, parIn, tgtAddrPhase, memHit, ioHit, tgtDataPhase, mstRdDataPhase} = '0;
  end

  // Released lines show the inverse so a stale value can never pass for a hold
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk);
    cfgWrite = 1'b1;
    cfgAddr = a;
    cfgByteEn = be;
    cfgWrData = d;
    @(negedge clk);
    cfgWrite = 1'b0;
    cfgAddr = ~a;
    cfgByteEn = ~be;
    cfgWrData = ~d;
  endtask : cfg_write

  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d, output logic v);
    @(negedge clk);
    cfgRead = 1'b1;
    cfgAddr = a;
    cfgByteEn = 4'hf;
    // Valid stands only in the cycle right after the taking edge
    @(negedge clk);
    v = cfgRdValid;
    d = cfgRdData;
    cfgRead = 1'b0;
    cfgAddr = ~a;
  endtask : cfg_read

  // Kind 0 address, 1 target data, 2 own read data; bad flips the parity bit
  task automatic bus_phase(input logic [1:0] kind, input logic mem, input logic io, input logic bad);
    @(negedge clk);
    tgtAddrPhase = (kind == 2'h0);
    tgtDataPhase = (kind == 2'h1);
    mstRdDataPhase = (kind == 2'h2);
    memHit = mem;
    ioHit = io;
    adIn = AD_PAT;
    cbeIn = CBE_PAT;
    @(negedge clk);
    {tgtAddrPhase, tgtDataPhase, mstRdDataPhase, memHit, ioHit} = '0;
    parIn = (^{CBE_PAT, AD_PAT}) ^ bad;
    adIn = ~AD_PAT;
    cbeIn = ~CBE_PAT;
  endtask : bus_phase
endmodule : pcc_host_model

/* File: tb/tb_pci_config_command_status.sv */
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failCount++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_pci_config_command_status;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [7:0] a; logic [3:0] be; logic [31:0] d; logic [31:0] e;} pcc_row_t;
  localparam logic [15:0] VEN = 16'h2b4d; // Arbitrary value
  localparam logic [15:0] DEV = 16'h7e19; // Arbitrary value
  localparam logic [31:0] IDENT = {DEV, VEN};
  // Medium decode code in 26:25 and capability list bit 20
  localparam logic [31:0] STS = 32'h0210_0000;
  localparam pcc_row_t ROWS [9] = '{
    '{1'b0, 8'h00, 4'hf, 32'h0, IDENT},
    '{1'b0, 8'h04, 4'hf, 32'h0, STS | 32'h7},
    '{1'b1, 8'h00, 4'hf, 32'hffff_ffff, IDENT},
    '{1'b1, 8'h04, 4'hf, 32'hffff_ffff, STS | 32'h147},
    '{1'b1, 8'h04, 4'h1, 32'h0, STS | 32'h100},
    '{1'b0, 8'h08, 4'hf, 32'h0, 32'h0},
    '{1'b1, 8'h3c, 4'hf, 32'hffff_ffff, 32'h0},
    '{1'b1, 8'h04, 4'h3, 32'h0000_0147, STS | 32'h147},
    '{1'b1, 8'h05, 4'h2, 32'h0, STS | 32'h47}};
  logic clk, rst, cfgRead, cfgWrite, cfgRdValid, parIn, tgtAddrPhase, memHit, ioHit, tgtDataPhase;
  logic mstRdDataPhase, mstWrPerrSeen, masterAbortEvt, targetAbortEvt, capLoadValid, capLoadValue;
  logic masterReqIn, masterReqOut, devselStart, perrOutN, perrOe, serrOutN, serrOe, rdV;
  logic [7:0] cfgAddr;
  logic [3:0] cfgByteEn, cbeIn;
  logic [31:0] cfgWrData, cfgRdData, adIn, rdD;
  int failCount = 0;
  int compares = 0;
  int cycles = 0;

  pcc_config_regs #(.VENDOR_CODE(VEN), .DEVICE_CODE(DEV)) dut (.clk(clk), .rst(rst), .cfgRead(cfgRead),
    .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
    .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .adIn(adIn), .cbeIn(cbeIn), .parIn(parIn),
    .tgtAddrPhase(tgtAddrPhase), .memHit(memHit), .ioHit(ioHit), .tgtDataPhase(tgtDataPhase),
    .mstRdDataPhase(mstRdDataPhase), .mstWrPerrSeen(mstWrPerrSeen), .masterAbortEvt(masterAbortEvt),
    .targetAbortEvt(targetAbortEvt), .capLoadValid(capLoadValid), .capLoadValue(capLoadValue),
    .masterReqIn(masterReqIn), .masterReqOut(masterReqOut), .devselStart(devselStart),
    .perrOutN(perrOutN), .perrOe(perrOe), .serrOutN(serrOutN), .serrOe(serrOe));

  pcc_host_model host (.clk(clk), .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgAddr(cfgAddr),
    .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
    .adIn(adIn), .cbeIn(cbeIn), .parIn(parIn), .tgtAddrPhase(tgtAddrPhase), .memHit(memHit),
    .ioHit(ioHit), .tgtDataPhase(tgtDataPhase), .mstRdDataPhase(mstRdDataPhase));

  initial clk = 1'b0;
  always #20 clk = ~clk;

  // The run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failCount++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (failCount == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    host.cfg_read(a, rdD, rdV);
    `CHK(rdV, 1'b1)
    `CHK(rdD, e)
  endtask : rd_chk

  task automatic claim(input logic mem, input logic io, input logic e);
    host.bus_phase(2'h0, mem, io, 1'b0);
    `CHK(devselStart, 1'b0)
    @(negedge clk);
    `CHK(devselStart, e)
    @(negedge clk);
    `CHK(devselStart, 1'b0)
  endtask : claim

  // One-cycle pulse on a side-band event input
  task automatic evt(input int k);
    @(negedge clk);
    {mstWrPerrSeen, masterAbortEvt, targetAbortEvt, capLoadValid} = 4'h8 >> k;
    @(negedge clk);
    {mstWrPerrSeen, masterAbortEvt, targetAbortEvt, capLoadValid} = 4'h0;
  endtask : evt

  initial
  begin
    {mstWrPerrSeen, masterAbortEvt, targetAbortEvt, capLoadValid, capLoadValue} = '0;
    masterReqIn = 1'b1;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    `CHK({perrOe, perrOutN, serrOe, serrOutN, devselStart}, 5'b01010)
    `CHK({masterReqOut, cfgRdValid, cfgRdData}, 34'h2_0000_0000)
    rst = 1'b0;
    foreach (ROWS[i])
    begin
      if (ROWS[i].wr)
        host.cfg_write(ROWS[i].a, ROWS[i].be, ROWS[i].d);
      rd_chk(ROWS[i].a, ROWS[i].e);
    end
    claim(1'b1, 1'b0, 1'b1);
    claim(1'b0, 1'b1, 1'b1);
    host.cfg_write(8'h04, 4'h1, 32'h44);
    claim(1'b1, 1'b0, 1'b0);
    claim(1'b0, 1'b1, 1'b0);
    `CHK(masterReqOut, 1'b1)
    masterReqIn = 1'b0;
    #1 `CHK(masterReqOut, 1'b0)
    masterReqIn = 1'b1;
    host.cfg_write(8'h04, 4'h1, 32'h43);
    `CHK(masterReqOut, 1'b0)
    host.cfg_write(8'h04, 4'h1, 32'h47);
    host.bus_phase(2'h1, 1'b0, 1'b0, 1'b1);
    repeat (2) @(negedge clk);
    `CHK({perrOe, perrOutN}, 2'b10)
    @(negedge clk);
    `CHK({perrOe, perrOutN}, 2'b11)
    @(negedge clk);
    `CHK(perrOe, 1'b0)
    rd_chk(8'h04, 32'h8210_0047);
    host.cfg_write(8'h04, 4'h8, 32'h0);
    rd_chk(8'h04, 32'h8210_0047);
    host.cfg_write(8'h04, 4'h8, 32'h8000_0000);
    rd_chk(8'h04, STS | 32'h47);
    host.cfg_write(8'h04, 4'h2, 32'h100);
    host.bus_phase(2'h0, 1'b0, 1'b0, 1'b1);
    repeat (2) @(negedge clk);
    `CHK({serrOe, serrOutN}, 2'b10)
    @(negedge clk);
    `CHK(serrOe, 1'b0)
    rd_chk(8'h04, 32'hc210_0147);
    host.cfg_write(8'h04, 4'h8, 32'hc000_0000);
    host.cfg_write(8'h04, 4'h1, 32'h07);
    host.bus_phase(2'h0, 1'b0, 1'b0, 1'b1);
    repeat (2) @(negedge clk);
    `CHK({serrOe, perrOe}, 2'b00)
    evt(0);
    rd_chk(8'h04, 32'h8210_0107);
    host.cfg_write(8'h04, 4'hb, 32'h8000_0147);
    host.bus_phase(2'h2, 1'b0, 1'b0, 1'b1);
    repeat (3) @(negedge clk);
    rd_chk(8'h04, 32'h8310_0147);
    host.cfg_write(8'h04, 4'h8, 32'hff00_0000);
    evt(0);
    rd_chk(8'h04, 32'h0310_0147);
    evt(1);
    evt(2);
    rd_chk(8'h04, 32'h3310_0147);
    evt(3);
    rd_chk(8'h04, 32'h3300_0147);
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rd_chk(8'h04, STS | 32'h7);
    report_and_stop();
  end
endmodule : tb_pci_config_command_status
